// ==== rtl/gpc_regs.svh ====
// Register offsets, field positions, reset values and pin constants for the pin control block
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

// ----------------------------------------------------------------------------
// Offsets (byte addresses, one word each)
// ----------------------------------------------------------------------------
`define GPC_CFG_BASE        8'h00
`define GPC_STATUS_OFS      8'hc0
`define GPC_MASK_OFS        8'hc4
`define GPC_EVLEVEL_OFS     8'hc8

// ----------------------------------------------------------------------------
// Pin control field positions
// ----------------------------------------------------------------------------
`define GPC_MUX_HI          13
`define GPC_MUX_LO          12
`define GPC_POL_BIT         11
`define GPC_BUF_OD_BIT      8
`define GPC_EDGE_EN_BIT     7
`define GPC_SENSE_HI        6
`define GPC_SENSE_LO        4
`define GPC_PWR_HI          3
`define GPC_PWR_LO          2
`define GPC_PULL_HI         1
`define GPC_PULL_LO         0
`define GPC_CFG_WMASK       32'h0000_39ff

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define GPC_CFG_RESET       32'h0000_0000
`define GPC_MASK_RESET      32'h0000_0000

// ----------------------------------------------------------------------------
// Pins without an internal pull-down (octal labels 111..117 and 120)
// ----------------------------------------------------------------------------
`define GPC_NO_PD_FIRST     9'h049
`define GPC_NO_PD_LAST      9'h04f
`define GPC_NO_PD_EXTRA     9'h050

`endif

// ==== rtl/gpc_pkg.sv ====
// Types and decode helpers shared by the pin control block
package gpc_pkg;

  // --------------------------------------------------------------------------
  // Event condition
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    GPC_EV_LOW  = 3'b000,
    GPC_EV_HIGH = 3'b001,
    GPC_EV_OFF  = 3'b010,
    GPC_EV_RISE = 3'b011,
    GPC_EV_FALL = 3'b100,
    GPC_EV_BOTH = 3'b101,
    GPC_EV_RSVD = 3'b110
  } gpc_ev_mode_t;

  // Power emulation source
  typedef enum logic [1:0] {
    GPC_PWR_MAIN = 2'b00,
    GPC_PWR_SEC  = 2'b01,
    GPC_PWR_RSV2 = 2'b10,
    GPC_PWR_RSV3 = 2'b11
  } gpc_pwr_sel_t;

  // Edge enable and three sense bits into one condition
  function automatic gpc_ev_mode_t gpc_decode_mode(input logic [3:0] bits);
    case (bits)
      4'h0:    gpc_decode_mode = GPC_EV_LOW;
      4'h1:    gpc_decode_mode = GPC_EV_HIGH;
      4'h4:    gpc_decode_mode = GPC_EV_OFF;
      4'hd:    gpc_decode_mode = GPC_EV_RISE;
      4'he:    gpc_decode_mode = GPC_EV_FALL;
      4'hf:    gpc_decode_mode = GPC_EV_BOTH;
      default: gpc_decode_mode = GPC_EV_RSVD;
    endcase
  endfunction

  function automatic logic gpc_mode_is_edge(input gpc_ev_mode_t m);
    gpc_mode_is_edge = (m == GPC_EV_RISE) || (m == GPC_EV_FALL) || (m == GPC_EV_BOTH);
  endfunction

endpackage

// ==== rtl/gpc_event_det.sv ====
// Per-pin event detector: level and edge conditions
`timescale 1ns/100ps

module gpc_event_det
  import gpc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Pin and configuration
  input  wire logic       pin_level,
  input  wire logic [3:0] mode_bits,
  input  wire logic       sense_invert,
  // Result
  output logic            pin_event,
  output logic            edge_event
);

  gpc_ev_mode_t mode;
  logic         sensed;
  logic         prev;
  logic         next_prev;
  logic         next_event;
  logic         next_edge;
  logic         rise;
  logic         fall;

  always_comb begin
    mode       = gpc_decode_mode(mode_bits);
    sensed     = pin_level ^ sense_invert;
    rise       = sensed & ~prev;
    fall       = ~sensed & prev;
    next_prev  = sensed;
    next_event = 1'b0;
    next_edge  = 1'b0;
    case (mode)
      GPC_EV_LOW:  next_event = ~sensed;
      GPC_EV_HIGH: next_event = sensed;
      GPC_EV_RISE: next_event = rise;
      GPC_EV_FALL: next_event = fall;
      GPC_EV_BOTH: next_event = rise | fall;
      default:     next_event = 1'b0;
    endcase
    next_edge = next_event & gpc_mode_is_edge(mode);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prev       <= 1'b0;
      pin_event  <= 1'b0;
      edge_event <= 1'b0;
    end else begin
      prev       <= next_prev;
      pin_event  <= next_event;
      edge_event <= next_edge;
    end
  end

endmodule // gpc_event_det

// ==== rtl/gpc_pin_ctrl.sv ====
// Pin control low fields: buffer type, event detection, power emulation, pulls
//
// Behaviour
// - Bit 8 picks push-pull at 0 and open drain at 1 for whatever function drives the pin.
// - Bit 7 enables edge detection and combines with the sense bits.
// - Bits 6:4 choose the pin condition that raises the pin event.
// - Edge-enable and sense decode as 0000 low, 0001 high, 0100 off, 1101 rise, 1110 fall, 1111 both.
// - Power field 00 tristates the output while the main rail is not good.
// - Power field 01 tristates the output while the secondary rail is not good.
// - Pull field 00 none, 01 pull-up, 10 pull-down, 11 none.
// - Pins 111 to 117 and 120 never enable a pull-down.
// - Only edge events may wake the shut-down ring oscillator.
// - A wake needs an edge event on a pin whose aggregator enable is set.
// - After reset every pin's event setting is low-level sensitive.
// - The unit clock is ungated while any enabled pin event is active.
// - With polarity set and a non-GPIO function muxed in, outputs and event sense invert.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps

`include "gpc_regs.svh"

module gpc_pin_ctrl
  import gpc_pkg::*;
#(
  parameter int       NUM_PINS  = 16,
  parameter bit [8:0] FIRST_PIN = 9'h048
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [31:0]         reg_rdata,
  // Rails
  input  wire logic                main_rail_good,
  input  wire logic                secondary_rail_good,
  // Function side, per pin
  input  wire logic [NUM_PINS-1:0] func_data,
  input  wire logic [NUM_PINS-1:0] func_drive,
  input  wire logic [NUM_PINS-1:0] aggr_enable,
  // Pad side, per pin
  input  wire logic [NUM_PINS-1:0] pad_in,
  output logic      [NUM_PINS-1:0] pad_out,
  output logic      [NUM_PINS-1:0] pad_oe,
  output logic      [NUM_PINS-1:0] pull_up_en,
  output logic      [NUM_PINS-1:0] pull_down_en,
  // Events and system
  output logic      [NUM_PINS-1:0] pin_event,
  output logic                     ring_wake,
  output logic                     clk_ungate,
  output logic                     irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [31:0]         pin_config_control [NUM_PINS];
  logic [31:0]         next_cfg           [NUM_PINS];
  logic [NUM_PINS-1:0] status;
  logic [NUM_PINS-1:0] next_status;
  logic [NUM_PINS-1:0] mask;
  logic [NUM_PINS-1:0] next_mask;
  logic [31:0]         next_rdata;
  logic [NUM_PINS-1:0] det_event;
  logic [NUM_PINS-1:0] det_edge;
  logic [NUM_PINS-1:0] sense_inv;
  logic [NUM_PINS-1:0] next_pad_out;
  logic [NUM_PINS-1:0] next_pad_oe;
  logic [NUM_PINS-1:0] next_pu;
  logic [NUM_PINS-1:0] next_pd;
  logic                next_wake;
  logic                next_ungate;
  logic                next_irq;

  // Register index of a config access, or NUM_PINS when not a config word
  function automatic int cfg_index(input logic [7:0] a);
    cfg_index = NUM_PINS;
    if (a[1:0] == 2'b00 && a >= `GPC_CFG_BASE && int'(a >> 2) < NUM_PINS) begin
      cfg_index = int'(a >> 2);
    end
  endfunction

  // Pin number has no internal pull-down
  function automatic logic no_pulldown(input int idx);
    logic [8:0] num;
    num         = FIRST_PIN + 9'(idx);
    no_pulldown = (num >= `GPC_NO_PD_FIRST && num <= `GPC_NO_PD_LAST) ||
                  (num == `GPC_NO_PD_EXTRA);
  endfunction

  // --------------------------------------------------------------------------
  // Event detection per pin
  // --------------------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_det
      // Sense flips only for a muxed-in function with polarity set
      assign sense_inv[i] = pin_config_control[i][`GPC_POL_BIT] &&
                            (pin_config_control[i][`GPC_MUX_HI:`GPC_MUX_LO] != 2'b00);
      gpc_event_det u_det (
        .mclk         (mclk),
        .resetn       (resetn),
        .pin_level    (pad_in[i]),
        .mode_bits    (pin_config_control[i][`GPC_EDGE_EN_BIT:`GPC_SENSE_LO]),
        .sense_invert (sense_inv[i]),
        .pin_event    (det_event[i]),
        .edge_event   (det_edge[i])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  always_comb begin
    int wi;
    int ri;
    wi          = cfg_index(reg_addr);
    ri          = wi;
    for (int i = 0; i < NUM_PINS; i++) begin
      next_cfg[i] = pin_config_control[i];
    end
    next_mask   = mask;
    next_rdata  = 32'h0000_0000;
    // Reading status clears it, but a new event in the same cycle survives
    next_status = status;
    if (reg_read && reg_addr == `GPC_STATUS_OFS) begin
      next_status = '0;
    end
    next_status = next_status | det_event;
    if (reg_write) begin
      if (wi < NUM_PINS) begin
        next_cfg[wi] = reg_wdata & `GPC_CFG_WMASK;
      end else if (reg_addr == `GPC_MASK_OFS) begin
        next_mask = reg_wdata[NUM_PINS-1:0];
      end
    end
    if (reg_read) begin
      if (ri < NUM_PINS) begin
        next_rdata = pin_config_control[ri];
      end else if (reg_addr == `GPC_STATUS_OFS) begin
        next_rdata[NUM_PINS-1:0] = status;
      end else if (reg_addr == `GPC_MASK_OFS) begin
        next_rdata[NUM_PINS-1:0] = mask;
      end else if (reg_addr == `GPC_EVLEVEL_OFS) begin
        next_rdata[NUM_PINS-1:0] = det_event;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_config_control[i] <= `GPC_CFG_RESET;
      end
      status    <= '0;
      mask      <= '0;
      reg_rdata <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < NUM_PINS; i++) begin
        pin_config_control[i] <= next_cfg[i];
      end
      status    <= next_status;
      mask      <= next_mask;
      reg_rdata <= next_rdata;
    end
  end

  // --------------------------------------------------------------------------
  // Pad control
  // --------------------------------------------------------------------------
  always_comb begin
    logic         data;
    logic         drive;
    logic         rail_ok;
    gpc_pwr_sel_t psel;
    data  = 1'b0;
    drive = 1'b0;
    rail_ok = 1'b0;
    psel  = GPC_PWR_MAIN;
    for (int i = 0; i < NUM_PINS; i++) begin
      data  = func_data[i] ^ sense_inv[i];
      drive = func_drive[i];
      psel  = gpc_pwr_sel_t'(pin_config_control[i][`GPC_PWR_HI:`GPC_PWR_LO]);
      case (psel)
        GPC_PWR_MAIN: rail_ok = main_rail_good;
        GPC_PWR_SEC:  rail_ok = secondary_rail_good;
        // Reserved codes: fall back to the main rail rather than drive blind
        default:      rail_ok = main_rail_good;
      endcase
      if (pin_config_control[i][`GPC_BUF_OD_BIT]) begin
        // Open drain only ever pulls low
        next_pad_out[i] = 1'b0;
        next_pad_oe[i]  = drive & ~data & rail_ok;
      end else begin
        next_pad_out[i] = data;
        next_pad_oe[i]  = drive & rail_ok;
      end
      case (pin_config_control[i][`GPC_PULL_HI:`GPC_PULL_LO])
        2'b01: begin
          next_pu[i] = 1'b1;
          next_pd[i] = 1'b0;
        end
        2'b10: begin
          next_pu[i] = 1'b0;
          next_pd[i] = ~no_pulldown(i);
        end
        default: begin
          next_pu[i] = 1'b0;
          next_pd[i] = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pad_out      <= '0;
      pad_oe       <= '0;
      pull_up_en   <= '0;
      pull_down_en <= '0;
    end else begin
      pad_out      <= next_pad_out;
      pad_oe       <= next_pad_oe;
      pull_up_en   <= next_pu;
      pull_down_en <= next_pd;
    end
  end

  // --------------------------------------------------------------------------
  // Wake, clock ungate and interrupt
  // --------------------------------------------------------------------------
  always_comb begin
    // Level events never wake; edge pulses only on aggregator-enabled pins
    next_wake   = |(det_edge & aggr_enable);
    // Detector already drops disabled and reserved modes; the live config
    // would lead the event by a cycle when a mode is rewritten
    next_ungate = |det_event;
    next_irq    = |(next_status & mask);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_event    <= '0;
      ring_wake    <= 1'b0;
      clk_ungate   <= 1'b0;
      irq          <= 1'b0;
    end else begin
      pin_event    <= det_event;
      ring_wake    <= next_wake;
      clk_ungate   <= next_ungate;
      irq          <= next_irq;
    end
  end

endmodule // gpc_pin_ctrl

// ==== test/gpc_pad_model.sv ====
// Pad wire and external driver model for the pin control block
`timescale 1ns/100ps

module gpc_pad_model #(
  parameter int NUM_PINS = 16
) (
  // Clock
  input  wire logic                mclk,
  // Block side of the pads
  input  wire logic [NUM_PINS-1:0] pad_out,
  input  wire logic [NUM_PINS-1:0] pad_oe,
  input  wire logic [NUM_PINS-1:0] pull_up_en,
  input  wire logic [NUM_PINS-1:0] pull_down_en,
  // External driver on the board
  input  wire logic [NUM_PINS-1:0] ext_en,
  input  wire logic [NUM_PINS-1:0] ext_lvl,
  output logic      [NUM_PINS-1:0] pad_in
);
  logic [NUM_PINS-1:0] held;

  // Undriven pin flips every cycle so a floating pad never reads as a clean level
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_lvl[i];
      else if (pull_up_en[i]) pad_in[i] = 1'b1;
      else if (pull_down_en[i]) pad_in[i] = 1'b0;
      else pad_in[i] = ~held[i];
    end
  end

  always_ff @(posedge mclk) held <= pad_in;
endmodule // gpc_pad_model

// ==== test/gpc_pin_checker.sv ====
// Port assertions for the pin control block
`timescale 1ns/100ps

module gpc_pin_checker #(
  parameter int NUM_PINS = 16
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                resetn,
  // Register port
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  input  wire logic [31:0]         reg_rdata,
  // Pins, rails and events
  input  wire logic                main_rail_good,
  input  wire logic                secondary_rail_good,
  input  wire logic [NUM_PINS-1:0] aggr_enable,
  input  wire logic [NUM_PINS-1:0] pad_oe,
  input  wire logic [NUM_PINS-1:0] pull_up_en,
  input  wire logic [NUM_PINS-1:0] pull_down_en,
  input  wire logic [NUM_PINS-1:0] pin_event,
  input  wire logic                ring_wake,
  input  wire logic                clk_ungate,
  input  wire logic                irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_mask_off;
    reg_write && reg_addr == 8'hc4 && reg_wdata == 32'h0;
  endsequence
  sequence s_mask_kept;
    !(reg_write && reg_addr == 8'hc4);
  endsequence

  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_cfg_reserved_zero: assert property (
    reg_read && reg_addr < 8'h40 |=> (reg_rdata & 32'hffff_c600) == 32'h0)
    else $error("unused config bits read nonzero");
  a_unmapped_reads_zero: assert property (
    reg_read && (reg_addr inside {[8'h40:8'hbc], [8'hcc:8'hff]}) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_mask_clears_irq: assert property (s_mask_off ##1 s_mask_kept |=> !irq)
    else $error("irq stays with mask cleared");
  a_rail_tristate: assert property (
    (!main_rail_good && !secondary_rail_good) [*2] |-> pad_oe == '0)
    else $error("pad driven with rails down");
  a_pull_exclusive: assert property ((pull_up_en & pull_down_en) == '0)
    else $error("pull-up and pull-down both on");
  a_no_pulldown: assert property (pull_down_en[8:1] == 8'h00)
    else $error("pull-down on a pin without one");
  a_wake_event: assert property (
    ring_wake |-> |(pin_event & (aggr_enable | $past(aggr_enable))))
    else $error("wake without enabled pin event");
  a_ungate_event: assert property (|pin_event |-> ##[0:1] clk_ungate)
    else $error("clock gated during pin event");
endmodule // gpc_pin_checker

bind gpc_pin_ctrl gpc_pin_checker #(.NUM_PINS(NUM_PINS)) chk_u (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .main_rail_good(main_rail_good), .secondary_rail_good(secondary_rail_good),
  .aggr_enable(aggr_enable), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
  .pull_down_en(pull_down_en), .pin_event(pin_event), .ring_wake(ring_wake),
  .clk_ungate(clk_ungate), .irq(irq));

// ==== test/test_gpc_pin_ctrl.sv ====
// Self-checking bench for the pin control block
`timescale 1ns/100ps

module test_gpc_pin_ctrl;
  localparam int NP = 16;
  logic          mclk, resetn, reg_write, reg_read, ring_wake, clk_ungate, irq;
  logic          main_rail_good, secondary_rail_good;
  logic [7:0]    reg_addr;
  logic [31:0]   reg_wdata, reg_rdata, rd_val;
  logic [NP-1:0] func_data, func_drive, aggr_enable, pad_in, pad_out, pad_oe;
  logic [NP-1:0] pull_up_en, pull_down_en, pin_event, ext_en, ext_lvl;
  int            fail_count, check_count, nf, nr, nw;

  gpc_pin_ctrl #(.NUM_PINS(NP)) dut_u (
    .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .main_rail_good(main_rail_good), .secondary_rail_good(secondary_rail_good),
    .func_data(func_data), .func_drive(func_drive), .aggr_enable(aggr_enable),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .pin_event(pin_event), .ring_wake(ring_wake),
    .clk_ungate(clk_ungate), .irq(irq));

  gpc_pad_model #(.NUM_PINS(NP)) pad_u (
    .mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .ext_en(ext_en), .ext_lvl(ext_lvl), .pad_in(pad_in));

  always #12.5 mclk = ~mclk;

  // --------------------
  // Access and compare
  // --------------------
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  // Pin 0 goes low for seven cycles then high; events and wakes counted over six cycles of each level
  task automatic run_mode(input logic [3:0] code, input logic ag, input int ef, er, ew);
    nf = 0;
    nr = 0;
    nw = 0;
    @(posedge mclk) aggr_enable[0] <= ag;
    wr(8'h00, {24'h0, code, 4'h0});
    cyc(4);
    @(posedge mclk) ext_lvl[0] <= 1'b0;
    repeat (6) begin
      cyc(1);
      nf += pin_event[0];
      nw += ring_wake;
    end
    chk(clk_ungate, code == 4'h0);
    @(posedge mclk) ext_lvl[0] <= 1'b1;
    repeat (6) begin
      cyc(1);
      nr += pin_event[0];
      nw += ring_wake;
    end
    chk(clk_ungate, code == 4'h1);
    chk(nf, ef);
    chk(nr, er);
    chk(nw, ew);
  endtask

  task automatic pad_case(input logic [31:0] c, input logic d, m, s, eo, eout);
    wr(8'h08, c);
    @(posedge mclk);
    func_data[2]        <= d;
    main_rail_good      <= m;
    secondary_rail_good <= s;
    cyc(3);
    chk(pad_oe[2], eo);
    if (eo) chk(pad_out[2], eout);
  endtask

  // --------------------
  // Tests
  // --------------------
  initial begin
    #(25 * 4000);
    fail_count++;
    report_and_stop;
  end

  initial begin
    {mclk, resetn, reg_write, reg_read, reg_addr, reg_wdata} = '0;
    {func_data, func_drive, aggr_enable} = '0;
    {main_rail_good, secondary_rail_good} = 2'b11;
    ext_en  = '1;
    ext_lvl = '1;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    rdc(8'h00, 32'h0);
    rdc(8'h3c, 32'h0);
    rdc(8'hc4, 32'h0);
    wr(8'h0c, 32'hffff_ffff);
    rdc(8'h0c, 32'h0000_39ff);
    wr(8'hfc, 32'hffff_ffff);
    rdc(8'hfc, 32'h0);
    run_mode(4'h0, 1'b1, 5, 1, 0);
    run_mode(4'h1, 1'b1, 1, 5, 0);
    run_mode(4'h4, 1'b1, 0, 0, 0);
    run_mode(4'hd, 1'b1, 0, 1, 1);
    run_mode(4'he, 1'b1, 1, 0, 1);
    run_mode(4'hf, 1'b1, 1, 1, 2);
    run_mode(4'h2, 1'b1, 0, 0, 0);
    run_mode(4'h5, 1'b1, 0, 0, 0);
    run_mode(4'hd, 1'b0, 0, 1, 0);
    // Interrupt: enabled, raised, held while level holds, cleared, then masked
    wr(8'hc4, 32'h1);
    rd(8'hc0, rd_val);
    wr(8'h00, 32'h0);
    @(posedge mclk) ext_lvl[0] <= 1'b0;
    cyc(5);
    chk(irq, 1'b1);
    rdc(8'hc8, 32'h1);
    rdc(8'hc0, 32'h1);
    @(posedge mclk) ext_lvl[0] <= 1'b1;
    cyc(4);
    rd(8'hc0, rd_val);
    rdc(8'hc0, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    wr(8'hc4, 32'h0);
    @(posedge mclk) ext_lvl[0] <= 1'b0;
    cyc(5);
    chk(irq, 1'b0);
    rdc(8'hc0, 32'h1);
    @(posedge mclk) ext_lvl[0] <= 1'b1;
    // Pad buffer, rail emulation and polarity on pin 2
    @(posedge mclk) func_drive[2] <= 1'b1;
    pad_case(32'h0000, 1, 1, 1, 1, 1);
    pad_case(32'h0000, 0, 1, 1, 1, 0);
    pad_case(32'h0100, 1, 1, 1, 0, 0);
    pad_case(32'h0100, 0, 1, 1, 1, 0);
    pad_case(32'h0000, 1, 0, 1, 0, 0);
    pad_case(32'h0000, 1, 0, 0, 0, 0);
    pad_case(32'h0004, 1, 1, 0, 0, 0);
    pad_case(32'h0004, 1, 0, 1, 1, 1);
    pad_case(32'h1800, 1, 1, 1, 1, 0);
    pad_case(32'h0800, 1, 1, 1, 1, 1);
    pad_case(32'h0008, 1, 0, 1, 0, 0);
    pad_case(32'h000c, 1, 1, 0, 1, 1);
    // Pulls on a pin without pull-down and on one with it
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, k);
      wr(8'h24, k);
      cyc(2);
      chk({pull_up_en[1], pull_down_en[1], pull_up_en[9], pull_down_en[9]},
          {k == 1, 1'b0, k == 1, k == 2});
    end
    report_and_stop;
  end
endmodule // test_gpc_pin_ctrl
